// ---- common/ipc_map.vh ----
// register map, field positions and constants of the interrupt priority registers
`ifndef IPC_MAP_VH
`define IPC_MAP_VH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define IPC_ADDR_W 5
`define IPC_DATA_W 16
`define IPC_NSRC 20
`define IPC_ZERO16 16'h0000

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IPC_OFF_PRIO0 5'h00
`define IPC_OFF_PRIO1 5'h01
`define IPC_OFF_PRIO2 5'h02

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define IPC_RST_PRIO 16'h0000
`define IPC_WMASK_PRIO0 16'hC3FF
`define IPC_WMASK_PRIO1 16'hFCFF
`define IPC_WMASK_PRIO2 16'hF3FF

// ----------------------------------------
// field ranges, priority register 0
// ----------------------------------------
`define IPC_F_LVD 15:14
`define IPC_F_DBG_RX 9:8
`define IPC_F_DBG_TX 7:6
`define IPC_F_DBG_TRACE 5:4
`define IPC_F_DBG_BKPT 3:2
`define IPC_F_DBG_STEP 1:0

// ----------------------------------------
// field ranges, priority register 1
// ----------------------------------------
`define IPC_F_PORT_B 15:14
`define IPC_F_PORT_C 13:12
`define IPC_F_PORT_D 11:10
`define IPC_F_FL_EMPTY 7:6
`define IPC_F_FL_DONE 5:4
`define IPC_F_FL_ERR 3:2
`define IPC_F_CLK_SYN 1:0

// ----------------------------------------
// field ranges, priority register 2
// ----------------------------------------
`define IPC_F_AS_RXF 15:14
`define IPC_F_AS_RXE 13:12
`define IPC_F_AS_TXI 9:8
`define IPC_F_AS_TXE 7:6
`define IPC_F_SS_TXE 5:4
`define IPC_F_SS_RXF 3:2
`define IPC_F_PORT_A 1:0

// ----------------------------------------
// field codes
// ----------------------------------------
`define IPC_CODE_OFF 2'h0
`define IPC_LVL_STEP 2'h1
// sources 1..5 use the level 1 to 3 encoding
`define IPC_DBG_MASK 20'h0003E

`endif

// ---- logic/ipc_prio_regs.v ----
// interrupt priority configuration registers 0 to 2 with level decode
`timescale 1ns/1ps
// source index order:
//  0 low-voltage detect
//  1 debug rx full, 2 debug tx empty, 3 debug trace,
//  4 debug breakpoint, 5 debug step counter
//  6 port B, 7 port C, 8 port D,
//  9 flash buffers empty, 10 flash done, 11 flash error,
//  12 clock synthesizer
//  13 async rx full, 14 async rx error, 15 async tx idle,
//  16 async tx empty, 17 sync tx empty,
//  18 sync rx full, 19 port A
`include "ipc_map.vh"

module ipc_prio_regs (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [`IPC_ADDR_W-1:0] addr_in,
  input wire [`IPC_DATA_W-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [`IPC_DATA_W-1:0] rdata_out,
  input wire [`IPC_NSRC-1:0] src_req_in,
  output reg [`IPC_NSRC-1:0] src_en_out,
  output reg [2*`IPC_NSRC-1:0] src_level_out,
  output reg [`IPC_NSRC-1:0] src_pend_out
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [`IPC_DATA_W-1:0] irq_priority_reg_0;
  reg [`IPC_DATA_W-1:0] irq_priority_reg_1;
  reg [`IPC_DATA_W-1:0] irq_priority_reg_2;

  // address hits, shared by write and read paths
  wire hit0;
  wire hit1;
  wire hit2;
  assign hit0 = (addr_in == `IPC_OFF_PRIO0);
  assign hit1 = (addr_in == `IPC_OFF_PRIO1);
  assign hit2 = (addr_in == `IPC_OFF_PRIO2);

  // whole-register write, reserved bits masked off; writes elsewhere dropped
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_priority_reg_0 <= `IPC_RST_PRIO;
      irq_priority_reg_1 <= `IPC_RST_PRIO;
      irq_priority_reg_2 <= `IPC_RST_PRIO;
    end else if (wr_in) begin
      if (hit0) begin
        irq_priority_reg_0 <= wdata_in & `IPC_WMASK_PRIO0;
      end
      if (hit1) begin
        irq_priority_reg_1 <= wdata_in & `IPC_WMASK_PRIO1;
      end
      if (hit2) begin
        irq_priority_reg_2 <= wdata_in & `IPC_WMASK_PRIO2;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------

  // read mux; unmapped offsets answer zero
  reg [`IPC_DATA_W-1:0] next_rdata;
  always @* begin
    next_rdata = `IPC_ZERO16;
    if (rd_in) begin
      if (hit0) begin
        next_rdata = irq_priority_reg_0 & `IPC_WMASK_PRIO0;
      end else if (hit1) begin
        next_rdata = irq_priority_reg_1 & `IPC_WMASK_PRIO1;
      end else if (hit2) begin
        next_rdata = irq_priority_reg_2 & `IPC_WMASK_PRIO2;
      end
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= `IPC_ZERO16;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // field gather, one 2-bit code per source
  // ----------------------------------------
  wire [2*`IPC_NSRC-1:0] code;

  // register 0: low-voltage detect and the debug unit
  assign code[1:0] = irq_priority_reg_0[`IPC_F_LVD];
  assign code[3:2] = irq_priority_reg_0[`IPC_F_DBG_RX];
  assign code[5:4] = irq_priority_reg_0[`IPC_F_DBG_TX];
  assign code[7:6] = irq_priority_reg_0[`IPC_F_DBG_TRACE];
  assign code[9:8] = irq_priority_reg_0[`IPC_F_DBG_BKPT];
  assign code[11:10] = irq_priority_reg_0[`IPC_F_DBG_STEP];

  // register 1: ports, flash and clock synthesizer
  assign code[13:12] = irq_priority_reg_1[`IPC_F_PORT_B];
  assign code[15:14] = irq_priority_reg_1[`IPC_F_PORT_C];
  assign code[17:16] = irq_priority_reg_1[`IPC_F_PORT_D];
  assign code[19:18] = irq_priority_reg_1[`IPC_F_FL_EMPTY];
  assign code[21:20] = irq_priority_reg_1[`IPC_F_FL_DONE];
  assign code[23:22] = irq_priority_reg_1[`IPC_F_FL_ERR];
  assign code[25:24] = irq_priority_reg_1[`IPC_F_CLK_SYN];

  // register 2: serial units and port A
  assign code[27:26] = irq_priority_reg_2[`IPC_F_AS_RXF];
  assign code[29:28] = irq_priority_reg_2[`IPC_F_AS_RXE];
  assign code[31:30] = irq_priority_reg_2[`IPC_F_AS_TXI];
  assign code[33:32] = irq_priority_reg_2[`IPC_F_AS_TXE];
  assign code[35:34] = irq_priority_reg_2[`IPC_F_SS_TXE];
  // the last two fields share the 0..2 encoding of their neighbours
  assign code[37:36] = irq_priority_reg_2[`IPC_F_SS_RXF];
  assign code[39:38] = irq_priority_reg_2[`IPC_F_PORT_A];

  // ----------------------------------------
  // per-source decode and forwarding
  // ----------------------------------------
  localparam [`IPC_NSRC-1:0] DBG_SRC = `IPC_DBG_MASK;

  // registered so every output comes from a flop; costs one cycle of
  // latency after a register write, harmless for configuration
  genvar gi;
  generate
    for (gi = 0; gi < `IPC_NSRC; gi = gi + 1) begin : g_src
      wire [1:0] fcode;
      wire on;
      wire [1:0] lvl;
      assign fcode = code[2*gi+1:2*gi];
      assign on = (fcode != `IPC_CODE_OFF);
      // debug codes map straight to 1..3, others shift down to 0..2
      assign lvl = DBG_SRC[gi] ? fcode : (fcode - `IPC_LVL_STEP);
      always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          src_en_out[gi] <= 1'b0;
          src_level_out[2*gi+1:2*gi] <= `IPC_CODE_OFF;
          src_pend_out[gi] <= 1'b0;
        end else begin
          src_en_out[gi] <= on;
          // disabled sources forward level zero to keep arbitration clean
          src_level_out[2*gi+1:2*gi] <= on ? lvl : `IPC_CODE_OFF;
          // a disabled field masks the request outright
          src_pend_out[gi] <= src_req_in[gi] & on;
        end
      end
    end
  endgenerate

endmodule

// ---- bench/ipc_src_model.sv ----
// request source model driving raw interrupt requests
`timescale 1ns/1ps
`include "ipc_map.vh"
module ipc_src_model (
  input wire ref_clk_in,
  output reg [`IPC_NSRC-1:0] req_out
);
  integer seed = 47213;
  // new random pattern after every rising edge, so pending sees all mixes
  initial req_out = 0;
  always @(posedge ref_clk_in) begin
    req_out <= $random(seed);
  end
endmodule

// ---- bench/ipc_prio_monitor.sv ----
// assertion checker for the interrupt priority registers
`timescale 1ns/1ps
`include "ipc_map.vh"
module ipc_prio_monitor (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [`IPC_ADDR_W-1:0] addr_in,
  input wire [`IPC_DATA_W-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [`IPC_DATA_W-1:0] rdata_out,
  input wire [`IPC_NSRC-1:0] src_req_in,
  input wire [`IPC_NSRC-1:0] src_en_out,
  input wire [2*`IPC_NSRC-1:0] src_level_out,
  input wire [`IPC_NSRC-1:0] src_pend_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // a write to register 0 reaches the source outputs two edges later
  sequence wr0_s;
    wr_in && addr_in == `IPC_OFF_PRIO0;
  endsequence
  // pending uses the enable of the same edge that loads src_en_out, so compare to the current enable
  pend_gate_a: assert property (src_pend_out == ($past(src_req_in) & src_en_out)) else $error("pend bad");
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == `IPC_ZERO16) else $error("rdata not idle");
  resv_read_a: assert property ($past(rd_in) |-> (rdata_out & ~($past(addr_in) == 0 ? `IPC_WMASK_PRIO0 :
    $past(addr_in) == 1 ? `IPC_WMASK_PRIO1 : `IPC_WMASK_PRIO2)) == 0) else $error("reserved bit set");
  unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) > `IPC_OFF_PRIO2 |-> rdata_out == 0)
    else $error("unmapped read");
  lvd_write_a: assert property (wr0_s |-> ##2 src_level_out[1:0] == ($past(wdata_in[`IPC_F_LVD], 2) == 0 ?
    2'h0 : $past(wdata_in[`IPC_F_LVD], 2) - 2'h1)) else $error("lvd level");
  dbg_write_a: assert property (wr0_s |-> ##2 src_level_out[3:2] == $past(wdata_in[`IPC_F_DBG_RX], 2))
    else $error("dbg level");
  lvd_range_a: assert property (src_level_out[1:0] != 2'h3) else $error("lvd range");
  dbg_level_a: assert property (src_en_out[5] |-> src_level_out[11:10] != 2'h0) else $error("dbg zero");
endmodule
bind ipc_prio_regs ipc_prio_monitor ipc_prio_monitor_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .src_req_in(src_req_in), .src_en_out(src_en_out), .src_level_out(src_level_out), .src_pend_out(src_pend_out));

// ---- bench/tb_top.sv ----
// self-checking bench for the interrupt priority registers
`timescale 1ns/1ps
`include "ipc_map.vh"
module tb_top;
  reg ref_clk_in, rst_in, wr_in, rd_in, rd_seen;
  reg [`IPC_ADDR_W-1:0] addr_in;
  reg [`IPC_DATA_W-1:0] wdata_in, e, rv;
  wire [`IPC_DATA_W-1:0] rdata_out;
  wire [`IPC_NSRC-1:0] src_req_in, src_en_out, src_pend_out;
  wire [2*`IPC_NSRC-1:0] src_level_out;
  logic [`IPC_DATA_W-1:0] exp_q[$], shadow[0:3];
  logic [`IPC_DATA_W-1:0] mask[0:3] = '{`IPC_WMASK_PRIO0, `IPC_WMASK_PRIO1, `IPC_WMASK_PRIO2, 16'h0000};
  logic [`IPC_NSRC-1:0] e_en, req_prev;
  logic [2*`IPC_NSRC-1:0] e_lv;
  integer bad_count = 0, samples_checked = 0, seed = 47213, i, c, n;
  ipc_prio_regs ipc_prio_regs_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .src_req_in(src_req_in),
    .src_en_out(src_en_out), .src_level_out(src_level_out), .src_pend_out(src_pend_out));
  ipc_src_model ipc_src_model_inst (.ref_clk_in(ref_clk_in), .req_out(src_req_in));
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task chk(input logic [39:0] got, input logic [39:0] want);
    samples_checked = samples_checked + 1;
    if (got !== want) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one bus cycle; shadow and queue note what the read must return
  task bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    if (w && a < 4) shadow[a] = d & mask[a];
    if (r) exp_q.push_back(a < 4 ? shadow[a] : 16'h0000);
    @(posedge ref_clk_in);
  endtask
  // expected enables and levels, all fields holding code c
  task lv_check;
    for (i = 0; i < `IPC_NSRC; i = i + 1) begin
      e_en[i] = c != 0;
      e_lv[2*i +: 2] = c == 0 ? 2'h0 : (i >= 1 && i <= 5) ? c[1:0] : c[1:0] - 2'h1;
    end
    chk(src_en_out, e_en);
    chk(src_pend_out, req_prev & e_en);
    chk(src_level_out, e_lv);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      chk(rdata_out, e);
    end
    rd_seen <= rd_in;
    req_prev <= src_req_in;
  end
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    {ref_clk_in, rst_in, wr_in, rd_in, rd_seen, addr_in, wdata_in} = 0;
    rst_in = 1;
    for (i = 0; i < 4; i = i + 1) shadow[i] = 0;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 0;
    @(posedge ref_clk_in);
    for (n = 0; n < 4; n = n + 1) bus(0, 1, n[4:0], 16'h0000);
    $display("test reset values done");
    for (c = 0; c < 4; c = c + 1) begin
      for (n = 0; n < 4; n = n + 1) bus(1, 0, n[4:0], {8{c[1:0]}});
      for (n = 0; n < 4; n = n + 1) bus(0, 1, n[4:0], 16'h0000);
      bus(0, 1, 5'h1F, 16'h0000);
      bus(0, 0, 5'h00, 16'h0000);
      #1;
      lv_check;
    end
    $display("test field codes done");
    // back-to-back write then read at random places, unmapped 3 too
    for (n = 0; n < 40; n = n + 1) begin
      c = $random(seed) & 3;
      rv = $random(seed);
      bus(1, 0, c[4:0], rv);
      bus(0, 1, c[4:0], 16'h0000);
    end
    bus(0, 0, 5'h00, 16'h0000);
    @(posedge ref_clk_in);
    $display("test random access done");
    print_verdict;
  end
endmodule
